// ==== verilog/cwp_pkg.sv ====
// constants and types for the configuration word protection and identification block
// =============================================================
package cwp_pkg;
	localparam int         ADDR_W        = 18;
	localparam int         IDX_W         = 16;
	localparam int         PA_W          = 14;
	// register indexes; byte address is four times the index
	localparam logic [15:0] IDX_REV      = 16'h8005;
	localparam logic [15:0] IDX_PART     = 16'h8006;
	localparam logic [15:0] IDX_PROT     = 16'h800A;
	localparam logic [15:0] IDX_CODE     = 16'h800B;
	localparam logic [15:0] IDX_CTRL     = 16'h8010;
	localparam logic [15:0] IDX_STAT     = 16'h8011;
	// protection word fields
	localparam int         B_LVP         = 13;
	localparam int         B_WP_SAF      = 11;
	localparam int         B_WP_EE       = 10;
	localparam int         B_WP_CFG      = 9;
	localparam int         B_WP_BOOT     = 8;
	localparam int         B_WP_APP      = 7;
	localparam int         B_SAF_EN      = 4;
	localparam int         B_BOOT_EN     = 3;
	localparam int         B_CP          = 0;
	localparam logic [13:0] PROT_IMPL    = 14'h2F9F;
	localparam logic [13:0] PROT_STICKY  = 14'h0F98;
	localparam logic [13:0] CODE_IMPL    = 14'h0001;
	localparam logic [13:0] ERASED       = 14'h3FFF;
	// control and status fields
	localparam int         C_ERASE       = 0;
	localparam int         C_LVP_SRC     = 1;
	localparam int         C_ERR_CLR     = 2;
	localparam int         S_ERR         = 0;
	localparam int         S_CP_ON       = 1;
	localparam int         S_LVP         = 2;
	localparam int         S_WORDS       = 16;
	// memory geometry in words
	localparam logic [14:0] PROG_WORDS   = 15'h4000;
	localparam logic [14:0] SAF_WORDS    = 15'h0080;
	localparam logic [14:0] W_512        = 15'h0200;
	localparam logic [14:0] W_1K         = 15'h0400;
	localparam logic [14:0] W_2K         = 15'h0800;
	localparam logic [14:0] W_4K         = 15'h1000;
	localparam logic [14:0] W_8K         = 15'h2000;
	localparam logic [1:0]  RESP_OK      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;
	typedef enum logic [2:0] {
		RG_APP  = 3'b001,
		RG_BOOT = 3'b010,
		RG_SAF  = 3'b100
	} cwp_region_t;
	typedef enum logic [2:0] {
		NV_PFM  = 3'b001,
		NV_EE   = 3'b010,
		NV_CFG  = 3'b100
	} cwp_nv_kind_t;
endpackage

// ==== verilog/cwp_top.sv ====
// configuration word decode, write protection checks and identification registers
module cwp_top
	import cwp_pkg::*;
#(
	parameter logic [5:0]  MAJOR_REV = 6'h01,  // arbitrary value
	parameter logic [5:0]  MINOR_REV = 6'h00,  // arbitrary value
	parameter logic [11:0] PART_CODE = 12'hA5C // arbitrary value
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              nv_wr_req,
	input  wire cwp_nv_kind_t      nv_wr_kind,
	input  wire logic [PA_W-1:0]   nv_wr_addr,
	input  wire logic              reset_pin_enable,
	input  wire logic [PA_W-1:0]   fetch_addr,
	output logic                   nv_wr_grant,
	output logic                   nv_wr_reject,
	output logic                   nv_write_error_flag,
	output logic                   reset_pin_is_master,
	output logic                   hv_prog_required,
	output logic                   code_protect_on,
	output logic                   fetch_violation,
	output cwp_region_t            nv_wr_region
);
	// =============================================================
	// decode functions
	function automatic logic [14:0] boot_words(input logic [13:0] w);
		logic [14:0] n;
		n = 15'h0;
		case (w[2:0])
			3'b111:  n = W_512;
			3'b110:  n = W_1K;
			3'b101:  n = W_2K;
			3'b100:  n = W_4K;
			default: n = W_8K;
		endcase
		if (n > (PROG_WORDS >> 1)) begin
			n = PROG_WORDS >> 1;
		end
		if (w[B_BOOT_EN]) begin
			n = 15'h0;
		end
		return n;
	endfunction

	function automatic cwp_region_t region_of(input logic [13:0] w, input logic [PA_W-1:0] a);
		cwp_region_t r;
		r = RG_APP;
		if ({1'b0, a} < boot_words(w)) begin
			r = RG_BOOT;
		end else if (!w[B_SAF_EN] && {1'b0, a} >= PROG_WORDS - SAF_WORDS) begin
			r = RG_SAF;
		end
		return r;
	endfunction

	// =============================================================
	// configuration state
	logic [13:0]       prot_r;
	logic [13:0]       code_r;
	logic              lvp_src_r;
	logic              err_r;
	logic              aw_have_r;
	logic              w_have_r;
	logic [IDX_W-1:0]  aw_idx_r;
	logic [31:0]       wdata_r;
	logic [3:0]        wstrb_r;
	logic              wr_go;
	logic              cfg_hit;
	logic              cfg_blocked;
	logic              erase;
	logic              err_clr;
	logic              reject_nxt;
	logic [13:0]       prot_nxt;
	logic [13:0]       wd;

	assign wr_go       = aw_have_r && w_have_r && !s_axi_bvalid;
	assign wd          = {wstrb_r[1] ? wdata_r[13:8] : 6'h3F, wstrb_r[0] ? wdata_r[7:0] : 8'hFF};
	assign cfg_hit     = wr_go && (aw_idx_r == IDX_PROT || aw_idx_r == IDX_CODE);
	assign cfg_blocked = cfg_hit && !prot_r[B_WP_CFG];
	assign erase       = wr_go && aw_idx_r == IDX_CTRL && wstrb_r[0] && wdata_r[C_ERASE];
	assign err_clr     = wr_go && aw_idx_r == IDX_CTRL && wstrb_r[0] && wdata_r[C_ERR_CLR];

	always_comb begin
		prot_nxt = (wd & PROT_IMPL) | ~PROT_IMPL;
		prot_nxt = (prot_nxt & ~PROT_STICKY) | (prot_r & wd & PROT_STICKY);
		if (lvp_src_r) begin
			prot_nxt[B_LVP] = prot_r[B_LVP] | wd[B_LVP];
		end
		if (!prot_r[B_BOOT_EN]) begin
			prot_nxt[2:0] = prot_r[2:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prot_r <= ERASED;
			code_r <= ERASED;
		end else if (erase) begin
			prot_r <= ERASED;
			code_r <= ERASED;
		end else if (cfg_hit && !cfg_blocked) begin
			if (aw_idx_r == IDX_PROT) begin
				prot_r <= prot_nxt;
			end else begin
				code_r <= (wd & CODE_IMPL) | ~CODE_IMPL;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lvp_src_r <= 1'b0;
		end else if (wr_go && aw_idx_r == IDX_CTRL && wstrb_r[0]) begin
			lvp_src_r <= wdata_r[C_LVP_SRC];
		end
	end

	// =============================================================
	// nonvolatile write path check
	always_comb begin
		reject_nxt = 1'b0;
		case (nv_wr_kind)
			NV_EE:  reject_nxt = !prot_r[B_WP_EE];
			NV_CFG: reject_nxt = !prot_r[B_WP_CFG];
			NV_PFM: begin
				case (region_of(prot_r, nv_wr_addr))
					RG_BOOT: reject_nxt = !prot_r[B_WP_BOOT];
					RG_SAF:  reject_nxt = !prot_r[B_WP_SAF];
					default: reject_nxt = !prot_r[B_WP_APP];
				endcase
			end
			default: reject_nxt = 1'b1;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			nv_wr_grant  <= 1'b0;
			nv_wr_reject <= 1'b0;
			nv_wr_region <= RG_APP;
		end else begin
			nv_wr_grant  <= nv_wr_req && !reject_nxt;
			nv_wr_reject <= nv_wr_req && reject_nxt;
			nv_wr_region <= region_of(prot_r, nv_wr_addr);
		end
	end

	// set wins over clear so a rejection in the clearing cycle is kept
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			err_r <= 1'b0;
		end else if ((nv_wr_req && reject_nxt) || cfg_blocked) begin
			err_r <= 1'b1;
		end else if (err_clr) begin
			err_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reset_pin_is_master <= 1'b1;
			hv_prog_required    <= 1'b0;
			code_protect_on     <= 1'b0;
			fetch_violation     <= 1'b0;
		end else begin
			reset_pin_is_master <= prot_r[B_LVP] || reset_pin_enable;
			hv_prog_required    <= !prot_r[B_LVP];
			code_protect_on     <= !code_r[B_CP];
			fetch_violation     <= region_of(prot_r, fetch_addr) == RG_SAF;
		end
	end
	assign nv_write_error_flag = err_r;

	// =============================================================
	// bus write channels; address and data taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r     <= 1'b0;
			w_have_r      <= 1'b0;
			aw_idx_r      <= '0;
			wdata_r       <= '0;
			wstrb_r       <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OK;
		end else begin
			s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_have_r && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_r <= 1'b1;
				aw_idx_r  <= s_axi_awaddr[ADDR_W-1:2];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_r <= 1'b1;
				wdata_r  <= s_axi_wdata;
				wstrb_r  <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_have_r    <= 1'b0;
				w_have_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (cfg_hit || aw_idx_r == IDX_CTRL) ? RESP_OK : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// =============================================================
	// bus read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OK;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= RESP_OK;
				case (s_axi_araddr[ADDR_W-1:2])
					IDX_REV:  s_axi_rdata <= {18'h0, 2'b10, MAJOR_REV, MINOR_REV};
					IDX_PART: s_axi_rdata <= {18'h0, 2'b11, PART_CODE};
					IDX_PROT: s_axi_rdata <= {18'h0, prot_r};
					IDX_CODE: s_axi_rdata <= {18'h0, code_r};
					IDX_CTRL: s_axi_rdata <= {30'h0, lvp_src_r, 1'b0};
					IDX_STAT: s_axi_rdata <= {1'b0, boot_words(prot_r), 13'h0, prot_r[B_LVP], !code_r[B_CP], err_r};
					default: begin
						s_axi_rdata <= '0;
						s_axi_rresp <= RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// =============================================================
	// checks
	lvp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		lvp_src_r && prot_r[B_LVP] && !erase |=> prot_r[B_LVP])
		else $error("low-voltage enable cleared from its own interface");
	sticky_bits_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!erase |=> ((~$past(prot_r) & prot_r & PROT_STICKY) == 14'h0))
		else $error("sticky bit returned to 1 without bulk erase");
	size_lock_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!prot_r[B_BOOT_EN] && !erase |=> prot_r[2:0] == $past(prot_r[2:0]))
		else $error("boot size changed while boot enabled");
	boot_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
		prot_r[B_BOOT_EN] |-> boot_words(prot_r) == 15'h0)
		else $error("boot size nonzero with boot disabled");
	ee_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
		nv_wr_req && nv_wr_kind == NV_EE && !prot_r[B_WP_EE] |=> nv_wr_reject && !nv_wr_grant && err_r)
		else $error("eeprom write not blocked");
	err_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
		nv_wr_reject |-> err_r)
		else $error("rejection did not raise write error flag");
	unimpl_one_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(prot_r | PROT_IMPL) == ERASED && (code_r | CODE_IMPL) == ERASED)
		else $error("unimplemented bit reads 0");
	cp_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
		##1 code_protect_on == !$past(code_r[B_CP]))
		else $error("code protection output wrong");
	hv_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!prot_r[B_LVP] |=> hv_prog_required && (reset_pin_is_master == $past(reset_pin_enable)))
		else $error("programming voltage decode wrong");
	saf_fetch_a: assert property (@(posedge aclk) disable iff (!aresetn)
		prot_r[B_SAF_EN] && $stable(prot_r) |=> !fetch_violation)
		else $error("fetch violation with storage area disabled");
	// protection decode on the nonvolatile write and fetch paths, plus erase, bus write and error flag checks
	ee_allow_a: assert property (@(posedge aclk) disable iff (!aresetn)
		nv_wr_req && nv_wr_kind == NV_EE && prot_r[B_WP_EE] |=> nv_wr_grant && !nv_wr_reject)
		else $error("eeprom write refused while unprotected");
	cfg_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
		nv_wr_req && nv_wr_kind == NV_CFG && !prot_r[B_WP_CFG] |=> nv_wr_reject && !nv_wr_grant)
		else $error("configuration write not blocked");
	saf_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
		nv_wr_req && nv_wr_kind == NV_PFM && !prot_r[B_SAF_EN] && !prot_r[B_WP_SAF]
		&& {1'b0, nv_wr_addr} >= PROG_WORDS - SAF_WORDS |=> nv_wr_reject && !nv_wr_grant)
		else $error("storage area write not blocked");
	boot_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
		nv_wr_req && nv_wr_kind == NV_PFM && !prot_r[B_BOOT_EN] && !prot_r[B_WP_BOOT]
		&& nv_wr_addr == 14'h0000 |=> nv_wr_reject && !nv_wr_grant)
		else $error("boot region write not blocked");
	app_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
		nv_wr_req && nv_wr_kind == NV_PFM && !prot_r[B_WP_APP] && {1'b0, nv_wr_addr} >= boot_words(prot_r)
		&& {1'b0, nv_wr_addr} < PROG_WORDS - SAF_WORDS |=> nv_wr_reject && !nv_wr_grant)
		else $error("application region write not blocked");
	boot_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
		nv_wr_req && !prot_r[B_BOOT_EN] && !prot_r[2] && nv_wr_addr == 14'h1FFF |=> nv_wr_region == RG_BOOT)
		else $error("largest boot region does not reach its last word");
	boot_half_a: assert property (@(posedge aclk) disable iff (!aresetn)
		nv_wr_req && nv_wr_addr == 14'h2000 |=> nv_wr_region != RG_BOOT)
		else $error("boot region exceeds half of program memory");
	boot_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
		prot_r[B_BOOT_EN] |=> nv_wr_region != RG_BOOT)
		else $error("boot region present while disabled");
	saf_exec_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!prot_r[B_SAF_EN] && {1'b0, fetch_addr} >= PROG_WORDS - SAF_WORDS |=> fetch_violation)
		else $error("fetch from enabled storage area not flagged");
	lvp_master_a: assert property (@(posedge aclk) disable iff (!aresetn)
		prot_r[B_LVP] |=> reset_pin_is_master && !hv_prog_required)
		else $error("low-voltage mode does not force master reset");
	erase_all_a: assert property (@(posedge aclk) disable iff (!aresetn)
		erase |=> prot_r == ERASED && code_r == ERASED)
		else $error("bulk erase did not restore both words");
	bus_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
		cfg_blocked |=> err_r && prot_r == $past(prot_r) && code_r == $past(code_r))
		else $error("protected configuration write took effect");
	err_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		err_r && !err_clr |=> err_r)
		else $error("write error flag dropped without clear");
	// identification words on the read channel
	rev_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && s_axi_araddr[ADDR_W-1:2] == IDX_REV
		|=> s_axi_rdata[31:12] == 20'h00002 && s_axi_rdata[11:6] == MAJOR_REV && s_axi_rdata[5:0] == MINOR_REV)
		else $error("revision word read wrong");
	part_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && s_axi_araddr[ADDR_W-1:2] == IDX_PART
		|=> s_axi_rdata[31:12] == 20'h00003 && s_axi_rdata[11:0] == PART_CODE)
		else $error("part word read wrong");
	wr_cov_c: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_bvalid && s_axi_bready);
	rej_cov_c: cover property (@(posedge aclk) disable iff (!aresetn) nv_wr_reject);
	erase_cov_c: cover property (@(posedge aclk) disable iff (!aresetn) erase && !prot_r[B_BOOT_EN]);
	blk_cov_c: cover property (@(posedge aclk) disable iff (!aresetn) cfg_blocked);
endmodule

// ==== dv/cwp_prog_model.sv ====
// far-side programmer model that issues nonvolatile write attempts
module cwp_prog_model
	import cwp_pkg::*;
(
	input  wire logic        aclk,
	output logic             nv_wr_req,
	output cwp_nv_kind_t     nv_wr_kind,
	output logic [PA_W-1:0]  nv_wr_addr,
	input  wire logic        nv_wr_grant,
	input  wire logic        nv_wr_reject,
	input  wire cwp_region_t nv_wr_region
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		nv_wr_req = 1'b0;
		nv_wr_kind = NV_PFM;
		nv_wr_addr = '0;
	end
	// =========================================
	// one attempt; the answer is taken two edges after the edge that drives the request
	task automatic attempt(input cwp_nv_kind_t k, input logic [PA_W-1:0] a, output logic g, output logic j,
		output cwp_region_t rg);
		@(posedge aclk);
		nv_wr_req <= 1'b1;
		nv_wr_kind <= k;
		nv_wr_addr <= a;
		@(posedge aclk);
		nv_wr_req <= 1'b0;
		// released address wanders so a stale value is never trusted
		nv_wr_addr <= ~a;
		@(posedge aclk);
		g = nv_wr_grant;
		j = nv_wr_reject;
		rg = nv_wr_region;
	endtask
endmodule

// ==== dv/cwp_top_test.sv ====
// self-checking bench for the configuration word protection block
module cwp_top_test
	import cwp_pkg::*;
	;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [5:0]  MJ = 6'h2A;   // arbitrary value
	localparam logic [5:0]  MN = 6'h15;   // arbitrary value
	localparam logic [11:0] PC = 12'h3C6; // arbitrary value
	logic              aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic              arvalid, arready, rvalid, rready, req, grant, reject, err_flag;
	logic              rpm, hv, cpo, fv, rpe;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [31:0]       wdata, rdata, d;
	logic [3:0]        wstrb;
	logic [1:0]        bresp, rresp, r;
	logic [PA_W-1:0]   naddr, fetch;
	cwp_nv_kind_t      kind;
	cwp_region_t       region;
	int                prot_m, code_m, lvp_m, err_m, mismatches, n_tests, i;
	int                pts[6] = '{0, 'h1FF, 'h200, 'h3F7F, 'h3F80, 'h3FFF};

	always #2.5 aclk = ~aclk;

	cwp_top #(.MAJOR_REV(MJ), .MINOR_REV(MN), .PART_CODE(PC)) dut_u (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .nv_wr_req(req),
		.nv_wr_kind(kind), .nv_wr_addr(naddr), .reset_pin_enable(rpe), .fetch_addr(fetch),
		.nv_wr_grant(grant), .nv_wr_reject(reject), .nv_write_error_flag(err_flag),
		.reset_pin_is_master(rpm), .hv_prog_required(hv), .code_protect_on(cpo),
		.fetch_violation(fv), .nv_wr_region(region));

	cwp_prog_model prog_u (.aclk(aclk), .nv_wr_req(req), .nv_wr_kind(kind), .nv_wr_addr(naddr),
		.nv_wr_grant(grant), .nv_wr_reject(reject), .nv_wr_region(region));

	// =========================================
	// checking and bus tasks
	task automatic final_report();
		if (mismatches == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("FAIL %0t got %h expected %h", $time, got, exp);
			mismatches++;
		end
	endtask
	task automatic tmo();
		$display("FAIL %0t no answer", $time);
		mismatches++;
		final_report();
	endtask
	task automatic wait_hi(ref logic s);
		int n;
		for (n = 0; n < 64; n++) begin
			@(posedge aclk);
			if (s)
				return;
		end
		tmo();
	endtask
	task automatic axi_wr(input logic [15:0] idx, input logic [31:0] v, output logic [1:0] rs);
		int n;
		logic aw_p, w_p;
		aw_p = 1'b1;
		w_p = 1'b1;
		@(posedge aclk);
		awaddr <= {idx, 2'b00};
		awvalid <= 1'b1;
		wdata <= v;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// address and data may be taken at different edges
		for (n = 0; n < 64 && (aw_p || w_p); n++) begin
			@(posedge aclk);
			if (awready) begin
				aw_p = 1'b0;
				awvalid <= 1'b0;
			end
			if (wready) begin
				w_p = 1'b0;
				wvalid <= 1'b0;
			end
		end
		if (aw_p || w_p)
			tmo();
		wait_hi(bvalid);
		rs = bresp;
		bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [15:0] idx, output logic [31:0] q, output logic [1:0] rs);
		@(posedge aclk);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		wait_hi(arready);
		arvalid <= 1'b0;
		wait_hi(rvalid);
		q = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask

	// =========================================
	// behavioural model of the configuration words
	function automatic int bw(int p);
		if (p[3])
			return 0;
		if (p[2])
			return 512 << (7 - (p & 7));
		return 8192;
	endfunction
	function automatic cwp_region_t rgn(int a);
		if (a < bw(prot_m))
			return RG_BOOT;
		if (!prot_m[4] && a >= 'h3F80)
			return RG_SAF;
		return RG_APP;
	endfunction
	task automatic wr_cfg(input logic [15:0] idx, input int v);
		axi_wr(idx, v, r);
		chk(r, RESP_OK);
		if (!prot_m[9])
			err_m = 1;
		else if (idx == IDX_CODE)
			code_m = 'h3FFE | v & 1;
		else
			prot_m = 'h1060 | prot_m & v & 'h0F98 | ((prot_m[3] ? v : prot_m) & 7)
				| ((lvp_m && !v[13] ? prot_m : v) & 'h2000);
	endtask
	task automatic ctrl(input int v);
		axi_wr(IDX_CTRL, v, r);
		chk(r, RESP_OK);
		lvp_m = v[1];
		if (v[2])
			err_m = 0;
		if (v[0]) begin
			prot_m = 'h3FFF;
			code_m = 'h3FFF;
		end
	endtask
	task automatic check_all();
		axi_rd(IDX_PROT, d, r);
		chk(d, prot_m);
		axi_rd(IDX_CODE, d, r);
		chk(d, code_m);
		axi_rd(IDX_STAT, d, r);
		chk(d, bw(prot_m) << 16 | prot_m[13] << 2 | !code_m[0] << 1 | err_m);
		chk({hv, rpm, cpo, err_flag}, {!prot_m[13], prot_m[13] | rpe, !code_m[0], err_m[0]});
	endtask
	task automatic nv(input cwp_nv_kind_t k, input int a);
		logic g, j;
		cwp_region_t rg;
		int ok;
		prog_u.attempt(k, a[PA_W-1:0], g, j, rg);
		ok = k == NV_EE ? prot_m[10] : k == NV_CFG ? prot_m[9] : k != NV_PFM ? 0 : rgn(a) == RG_BOOT ? prot_m[8]
			: rgn(a) == RG_SAF ? prot_m[11] : prot_m[7];
		if (!ok)
			err_m = 1;
		chk({g, j}, {ok[0], !ok[0]});
		if (k == NV_PFM)
			chk(rg, rgn(a));
	endtask
	task automatic fetch_chk(input int a);
		fetch <= a[PA_W-1:0];
		repeat (2) @(posedge aclk);
		chk(fv, !prot_m[4] && a >= 'h3F80);
	endtask

	// =========================================
	// main sequence
	initial begin
		{aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, rpe} = '0;
		{awaddr, araddr, wdata, fetch} = '0;
		wstrb = 4'hF;
		{mismatches, n_tests, lvp_m, err_m} = '0;
		prot_m = 'h3FFF;
		code_m = 'h3FFF;
		void'($urandom(16));
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		check_all();
		axi_rd(IDX_REV, d, r);
		chk(d, {18'h0, 2'b10, MJ, MN});
		axi_rd(IDX_PART, d, r);
		chk(d, {18'h0, 2'b11, PC});
		axi_wr(IDX_REV, 'h0, r);
		chk(r, RESP_SLVERR);
		axi_rd(16'h8007, d, r);
		chk(r, RESP_SLVERR);
		chk(d, 0);
		for (i = 0; i < 8; i++) begin
			ctrl(1);
			wr_cfg(IDX_PROT, 'h2F90 | i);
			wr_cfg(IDX_PROT, 'h2F98 | ~i & 7);
			check_all();
			nv(NV_PFM, bw(prot_m) - 1);
			nv(NV_PFM, bw(prot_m));
		end
		ctrl(1);
		wr_cfg(IDX_PROT, 'h26E7);
		wr_cfg(IDX_PROT, 'h3FFF);
		check_all();
		for (i = 0; i < 6; i++) begin
			nv(NV_PFM, pts[i]);
			fetch_chk(pts[i]);
		end
		for (i = 0; i < 24; i++) begin
			nv(cwp_nv_kind_t'(3'b001 << ($urandom % 3)), $urandom % 16384);
			fetch_chk($urandom % 16384);
		end
		check_all();
		ctrl(4);
		check_all();
		wr_cfg(IDX_PROT, prot_m & ~'h680);
		nv(NV_EE, 0);
		nv(NV_CFG, 0);
		nv(NV_PFM, 'h1000);
		nv(cwp_nv_kind_t'(3'b011), 'h1000);
		wr_cfg(IDX_PROT, 'h0);
		check_all();
		ctrl(7);
		wr_cfg(IDX_PROT, 'h1FFF);
		check_all();
		ctrl(0);
		wr_cfg(IDX_PROT, 'h1FFF);
		for (i = 0; i < 2; i++) begin
			rpe <= i[0];
			check_all();
		end
		wr_cfg(IDX_CODE, 'h0);
		check_all();
		wr_cfg(IDX_CODE, 'h1);
		check_all();
		final_report();
	end
endmodule
